/* sfs_pkg.sv */
// Package: constants and carrier types for the safety function select block
`default_nettype none
package sfs_pkg;
  // Control word bit positions
  localparam int CW_TORQUE_OFF = 0;
  localparam int CW_TIMED_STOP = 1;
  localparam int CW_STOP_TWO = 2;
  localparam int CW_OP_STOP = 3;
  localparam int CW_LIM_SPEED = 4;
  localparam int CW_EVENT_ACK = 7;
  localparam int CW_SPEED_SEL_LO = 9;
  localparam int CW_DIR_POS = 12;
  localparam int CW_DIR_NEG = 13;
  // Status word bit positions
  localparam int SW_TORQUE_OFF = 0;
  localparam int SW_TIMED_STOP = 1;
  localparam int SW_EVENT = 7;
  // Enable-bits field positions
  localparam int EN_TERMINAL = 0;
  localparam int EN_EXTENDED = 2;
  localparam int EN_TELEGRAM = 3;
  // Telegram type carried on the safety channel
  localparam logic [7:0] TELEGRAM_TYPE = 8'h1E;
  // Reset values
  localparam logic [15:0] CW_RESET = 16'h0000;
  localparam logic [15:0] SW_RESET = 16'h0001;
  // Pulse-enable terminal sampling: minimum 1 ms at 125 MHz
  localparam int CLK_HZ = 125000000;
  localparam int EP_MIN_SAMPLE_US = 1000;
  localparam int EP_MIN_SAMPLE_CYC = (CLK_HZ / 1000000) * EP_MIN_SAMPLE_US;

  typedef struct packed {
    logic torque_off;
    logic timed_stop;
    logic stop_two;
    logic op_stop;
    logic lim_speed;
    logic [1:0] speed_level;
    logic dir_pos;
    logic dir_neg;
  } sfs_select_t;
endpackage
`default_nettype wire

/* sfs_select_ctrl.sv */
// Safety function select: dual-channel terminals, safety telegram decode, status word
//
// Operation
// (RULE_01) Terminal low selects, high deselects torque-off
// (RULE_02) Host changes both channels within tolerance
// (RULE_03) Channel mismatch past tolerance raises discrepancy fault
// (RULE_04) Either channel selecting cancels pulses at once
// (RULE_05) Terminal selection acts only on this drive
// (RULE_06) Tolerance shorter than shortest switching interval
// (RULE_07) Zero debounce reacts to every level change
// (RULE_08) Per-channel debounce suppresses short test pulses
// (RULE_09) Bit 3 enables telegram, bit 2 extended
// (RULE_10) Bit 0 adds terminals parallel to telegram
// (RULE_11) Torque-off wins over timed stop
// (RULE_12) Each drive is own slave, telegram 30
// (RULE_13) Safety words occupy first process word
// (RULE_14) Basic word: bit0, bit1 selects, bit7 ack
// (RULE_15) Host zeroes non-basic control bits; the host model clears only bits 2-4 and 9-10
// (RULE_16) Basic status: bits 0,1,7, others zero
// (RULE_17) Extended adds active-low selects 2,3,4,12,13
// (RULE_18) Bits 9-10 pick one of four limits
// (RULE_19) Pulse-enable terminal sampled at least 1 ms
// (RULE_20) Status bits 9-10 show active limit level; code keeps them zero and drives the level on active_speed_level
// (RULE_21) Event clears on ack fall once fault gone
// (RULE_22) Reserved bits ignored in, zero out
`default_nettype none
module sfs_select_ctrl #(
  parameter int TIME_W = 24,
  parameter int EP_SAMPLE_CYC = sfs_pkg::EP_MIN_SAMPLE_CYC
) (
  input wire logic clk, // 125 MHz control clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic cu_terminal, // Control-unit select terminal
  input wire logic pulse_enable_terminal, // Power-unit select terminal
  input wire logic [3:0] cu_safety_enable_bits, // Control-unit enable bits
  input wire logic [3:0] mm_safety_enable_bits, // Power-unit enable bits
  input wire logic [TIME_W-1:0] cu_changeover_tolerance, // Tolerance in cycles, CU
  input wire logic [TIME_W-1:0] mm_changeover_tolerance, // Tolerance in cycles, power unit
  input wire logic [TIME_W-1:0] cu_input_debounce_time, // Debounce in cycles, CU
  input wire logic [TIME_W-1:0] mm_input_debounce_time, // Debounce in cycles, power unit
  input wire logic [15:0] first_process_word, // Received safety control word
  input wire logic word_valid, // Control word strobe
  input wire logic fault_present, // Other internal fault source
  output logic [15:0] safety_state_word_one, // Transmitted basic status word
  output logic [1:0] active_speed_level, // Active speed-limit level
  output logic pulse_cancel, // Output pulses cancelled
  output logic discrepancy_fault, // Sticky channel discrepancy, stop-F
  output logic [7:0] telegram_type, // Telegram type of this slave
  output var sfs_pkg::sfs_select_t selects // Decoded active selects
);

  function automatic logic sat_ge(input logic [TIME_W-1:0] cnt, input logic [TIME_W-1:0] lim);
    sat_ge = (cnt >= lim);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three flops, change counted when last two agree
  logic [2:0] cu_sync;
  logic [2:0] ep_sync;
  logic cu_raw;
  logic ep_raw;
  logic [TIME_W-1:0] ep_tick;
  logic [TIME_W-1:0] next_ep_tick;
  logic ep_sampled;
  logic next_ep_sampled;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cu_sync <= 3'h7;
      ep_sync <= 3'h7;
      cu_raw <= 1'b1;
      ep_raw <= 1'b1;
    end else begin
      cu_sync <= {cu_sync[1:0], cu_terminal};
      ep_sync <= {ep_sync[1:0], pulse_enable_terminal};
      if (cu_sync[2] == cu_sync[1]) begin
        cu_raw <= cu_sync[2];
      end
      if (ep_sync[2] == ep_sync[1]) begin
        ep_raw <= ep_sync[2];
      end
    end
  end

  // (RULE_19) Periodic terminal sampling
  always_comb begin
    next_ep_tick = ep_tick + 1'b1;
    next_ep_sampled = ep_sampled;
    if (ep_tick >= TIME_W'(EP_SAMPLE_CYC - 1)) begin
      next_ep_tick = '0;
      next_ep_sampled = ep_raw;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ep_tick <= '0;
      ep_sampled <= 1'b1;
    end else begin
      ep_tick <= next_ep_tick;
      ep_sampled <= next_ep_sampled;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Debounce: a level must hold for the debounce time; zero time passes at once
  logic cu_deb;
  logic ep_deb;
  logic next_cu_deb;
  logic next_ep_deb;
  logic [TIME_W-1:0] cu_db_cnt;
  logic [TIME_W-1:0] ep_db_cnt;
  logic [TIME_W-1:0] next_cu_db_cnt;
  logic [TIME_W-1:0] next_ep_db_cnt;

  // (RULE_07) (RULE_08) Per-channel debounce
  always_comb begin
    next_cu_deb = cu_deb;
    next_ep_deb = ep_deb;
    next_cu_db_cnt = '0;
    next_ep_db_cnt = '0;
    if (cu_raw != cu_deb) begin
      next_cu_db_cnt = cu_db_cnt + 1'b1;
      if (sat_ge(cu_db_cnt, cu_input_debounce_time)) begin
        next_cu_deb = cu_raw;
        next_cu_db_cnt = '0;
      end
    end
    if (ep_sampled != ep_deb) begin
      next_ep_db_cnt = ep_db_cnt + 1'b1;
      if (sat_ge(ep_db_cnt, mm_input_debounce_time)) begin
        next_ep_deb = ep_sampled;
        next_ep_db_cnt = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cu_deb <= 1'b1;
      ep_deb <= 1'b1;
      cu_db_cnt <= '0;
      ep_db_cnt <= '0;
    end else begin
      cu_deb <= next_cu_deb;
      ep_deb <= next_ep_deb;
      cu_db_cnt <= next_cu_db_cnt;
      ep_db_cnt <= next_ep_db_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Discrepancy cross-comparison
  logic [TIME_W-1:0] disc_cnt;
  logic [TIME_W-1:0] next_disc_cnt;
  logic disc;
  logic next_disc;
  logic [TIME_W-1:0] tol;
  logic ack_fall;

  // Shorter of the two tolerances governs, so either channel's limit is honoured
  assign tol = (cu_changeover_tolerance < mm_changeover_tolerance) ?
               cu_changeover_tolerance : mm_changeover_tolerance;

  // (RULE_03) Mismatch timeout
  always_comb begin
    next_disc_cnt = '0;
    next_disc = disc;
    // (RULE_21) Ack fall clears once channels agree
    if (ack_fall && (cu_deb == ep_deb)) begin
      next_disc = 1'b0;
    end
    if (cu_deb != ep_deb) begin
      next_disc_cnt = disc_cnt + 1'b1;
      if (sat_ge(disc_cnt, tol)) begin
        next_disc = 1'b1;
        next_disc_cnt = disc_cnt;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Telegram decode and acknowledge
  logic [15:0] cw;
  logic [15:0] next_cw;
  logic ack_prev;
  logic event_flag;
  logic next_event_flag;
  logic tele_en;
  logic ext_mode;
  logic term_en;

  // (RULE_09) (RULE_10) Enables must agree on both channels
  assign tele_en = cu_safety_enable_bits[sfs_pkg::EN_TELEGRAM] &
                   mm_safety_enable_bits[sfs_pkg::EN_TELEGRAM];
  assign ext_mode = cu_safety_enable_bits[sfs_pkg::EN_EXTENDED] &
                    mm_safety_enable_bits[sfs_pkg::EN_EXTENDED];
  assign term_en = !tele_en | (cu_safety_enable_bits[sfs_pkg::EN_TERMINAL] &
                               mm_safety_enable_bits[sfs_pkg::EN_TERMINAL]);

  // (RULE_13) (RULE_22) Latch first process word, reserved bits dropped later
  always_comb begin
    next_cw = cw;
    if (word_valid) begin
      next_cw = first_process_word;
    end
  end

  // (RULE_14) Ack falling edge
  assign ack_fall = ack_prev & ~cw[sfs_pkg::CW_EVENT_ACK];

  // (RULE_21) Event set wins; cleared only on ack fall with fault gone
  always_comb begin
    next_event_flag = event_flag;
    if (ack_fall && !fault_present && !next_disc) begin
      next_event_flag = 1'b0;
    end
    if (fault_present || next_disc) begin
      next_event_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      disc_cnt <= '0;
      disc <= 1'b0;
      cw <= sfs_pkg::CW_RESET;
      ack_prev <= 1'b0;
      event_flag <= 1'b0;
    end else begin
      disc_cnt <= next_disc_cnt;
      disc <= next_disc;
      cw <= next_cw;
      ack_prev <= cw[sfs_pkg::CW_EVENT_ACK];
      event_flag <= next_event_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Select combination and status word
  sfs_pkg::sfs_select_t next_sel;
  logic next_pulse_cancel;
  logic [15:0] next_sw;
  logic tele_sto;
  logic tele_ss1;

  always_comb begin
    // (RULE_14) Active-low telegram selects
    tele_sto = tele_en & ~cw[sfs_pkg::CW_TORQUE_OFF];
    tele_ss1 = tele_en & ~cw[sfs_pkg::CW_TIMED_STOP];
    next_sel = '0;
    // (RULE_01) (RULE_04) (RULE_05) Either channel low selects for this drive
    next_sel.torque_off = tele_sto | (term_en & (~cu_deb | ~ep_deb)) | disc;
    // (RULE_11) Torque-off has priority
    next_sel.timed_stop = tele_ss1 & ~next_sel.torque_off;
    if (tele_en && ext_mode) begin
      // (RULE_17) Extended active-low selects
      next_sel.stop_two = ~cw[sfs_pkg::CW_STOP_TWO];
      next_sel.op_stop = ~cw[sfs_pkg::CW_OP_STOP];
      next_sel.lim_speed = ~cw[sfs_pkg::CW_LIM_SPEED];
      next_sel.dir_pos = ~cw[sfs_pkg::CW_DIR_POS];
      next_sel.dir_neg = ~cw[sfs_pkg::CW_DIR_NEG];
      // (RULE_18) Speed-limit code
      next_sel.speed_level = cw[sfs_pkg::CW_SPEED_SEL_LO +: 2];
    end
    next_pulse_cancel = next_sel.torque_off;
    // (RULE_16) (RULE_22) Basic status, all else zero
    next_sw = '0;
    next_sw[sfs_pkg::SW_TORQUE_OFF] = next_sel.torque_off;
    next_sw[sfs_pkg::SW_TIMED_STOP] = next_sel.timed_stop;
    next_sw[sfs_pkg::SW_EVENT] = next_event_flag;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      selects <= '0;
      pulse_cancel <= 1'b1;
      safety_state_word_one <= sfs_pkg::SW_RESET;
      active_speed_level <= 2'h0;
      discrepancy_fault <= 1'b0;
      telegram_type <= 8'h00;
    end else begin
      selects <= next_sel;
      // (RULE_04) Pulse cancel follows torque-off select
      pulse_cancel <= next_pulse_cancel;
      safety_state_word_one <= next_sw;
      // (RULE_20) Active level mirrors selection
      active_speed_level <= next_sel.speed_level;
      discrepancy_fault <= next_disc;
      // (RULE_12) Slave telegram type
      telegram_type <= sfs_pkg::TELEGRAM_TYPE;
    end
  end

endmodule
`default_nettype wire

/* sfs_select_ctrl_properties.sv */
// Port-level assertions for the safety function select block
`default_nettype none
module sfs_select_ctrl_properties (
  input wire logic clk, // Control clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [3:0] cu_safety_enable_bits, // CU enables
  input wire logic [3:0] mm_safety_enable_bits, // Power-unit enables
  input wire logic [15:0] first_process_word, // Control word
  input wire logic word_valid, // Word strobe
  input wire logic [15:0] safety_state_word_one, // Status word
  input wire logic [1:0] active_speed_level, // Speed level
  input wire logic pulse_cancel, // Pulses cancelled
  input wire logic discrepancy_fault, // Discrepancy fault
  input wire logic [7:0] telegram_type // Telegram type
);
  logic tel_on;
  logic ext_on;
  logic [1:0] cw_code;
  assign tel_on = cu_safety_enable_bits[3] & mm_safety_enable_bits[3];
  assign ext_on = tel_on & cu_safety_enable_bits[2] & mm_safety_enable_bits[2];
  assign cw_code = first_process_word[10:9];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  property p_cancel;
    pulse_cancel == safety_state_word_one[0];
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel differs from status");
  property p_zero;
    (safety_state_word_one & 16'hFF7C) == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("status spare bit set");
  property p_prio;
    !(safety_state_word_one[0] && safety_state_word_one[1]);
  endproperty
  a_prio: assert property (p_prio) else $error("timed stop beside torque off");
  property p_type;
    $past(arst_n) |-> telegram_type == sfs_pkg::TELEGRAM_TYPE;
  endproperty
  a_type: assert property (p_type) else $error("telegram type wrong");
  property p_sel;
    word_valid && tel_on && !first_process_word[0] |-> ##2 pulse_cancel;
  endproperty
  a_sel: assert property (p_sel) else $error("word select not obeyed");
  property p_fault;
    discrepancy_fault[*3] |-> pulse_cancel && safety_state_word_one[7];
  endproperty
  a_fault: assert property (p_fault) else $error("fault without stop");
  property p_basic;
    (!ext_on)[*3] |-> active_speed_level == 2'h0;
  endproperty
  a_basic: assert property (p_basic) else $error("level outside extended");
  property p_lvl;
    word_valid && ext_on |-> ##2 active_speed_level == $past(cw_code, 2);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level not from word");
endmodule
bind sfs_select_ctrl sfs_select_ctrl_properties u_props (
  .clk(clk), .arst_n(arst_n), .cu_safety_enable_bits(cu_safety_enable_bits),
  .mm_safety_enable_bits(mm_safety_enable_bits), .first_process_word(first_process_word),
  .word_valid(word_valid), .safety_state_word_one(safety_state_word_one),
  .active_speed_level(active_speed_level), .pulse_cancel(pulse_cancel),
  .discrepancy_fault(discrepancy_fault), .telegram_type(telegram_type)
);
`default_nettype wire

/* sfs_host_model.sv */
// Fail-safe host and terminal source model
`default_nettype none
module sfs_host_model (
  input wire logic clk, // Bench clock
  output logic [15:0] word, // Control word
  output logic valid, // Word strobe
  output logic cu_term, // Control-unit channel
  output logic mm_term // Power-unit channel
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    word = 16'h0000;
    valid = 1'b0;
    cu_term = 1'b1;
    mm_term = 1'b1;
  end
  task automatic send(input logic [15:0] w, input logic basic);
    @(posedge clk);
    #1;
    word = basic ? (w & 16'hF9E3) : w;
    valid = 1'b1;
    @(posedge clk);
    #1;
    valid = 1'b0;
    // Stale word inverted so nothing leans on old data
    word = ~word;
  endtask
  task automatic terms(input logic cu, input logic mm, input int skew);
    @(posedge clk);
    #1;
    cu_term = cu;
    repeat (skew) @(posedge clk);
    #1;
    mm_term = mm;
  endtask
endmodule
`default_nettype wire

/* sfs_select_ctrl_tb.sv */
// Self-checking bench for the safety function select block
`default_nettype none
module sfs_select_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic arst_n;
  logic [3:0] en;
  logic [23:0] tol;
  logic [23:0] deb;
  logic fault;
  logic [15:0] cw;
  logic cw_v;
  logic cu_t;
  logic mm_t;
  logic [15:0] sw;
  logic [1:0] lvl;
  logic pc;
  logic disc;
  logic [7:0] tt;
  sfs_pkg::sfs_select_t sel;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int seen;
  logic [15:0] wt [4] = '{16'hF963, 16'hF962, 16'hF961, 16'hF960};
  logic [15:0] st [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0001};
  sfs_select_ctrl #(.TIME_W(24), .EP_SAMPLE_CYC(4)) dut (
    .clk(clk), .arst_n(arst_n), .cu_terminal(cu_t), .pulse_enable_terminal(mm_t),
    .cu_safety_enable_bits(en), .mm_safety_enable_bits(en),
    .cu_changeover_tolerance(tol), .mm_changeover_tolerance(tol),
    .cu_input_debounce_time(deb), .mm_input_debounce_time(deb),
    .first_process_word(cw), .word_valid(cw_v), .fault_present(fault),
    .safety_state_word_one(sw), .active_speed_level(lvl), .pulse_cancel(pc),
    .discrepancy_fault(disc), .telegram_type(tt), .selects(sel)
  );
  sfs_host_model host (.clk(clk), .word(cw), .valid(cw_v), .cu_term(cu_t), .mm_term(mm_t));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_pc(input logic exp, input int lim);
    for (int k = 0; k < lim && pc !== exp; k++) begin
      @(posedge clk);
      #1;
    end
    chk("pulse_cancel", {15'h0, exp}, {15'h0, pc});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ack;
    host.send(16'hF9E3, 1'b1);
    host.send(16'hF963, 1'b1);
    settle(3);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    arst_n = 1'b0;
    en = 4'h8;
    tol = 24'h000028;
    deb = 24'h000000;
    fault = 1'b0;
    settle(3);
    chk("reset status", sfs_pkg::SW_RESET, sw);
    arst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.send(wt[i], 1'b1);
      settle(2);
      chk("basic status", st[i], sw);
    end
    chk("telegram type", 16'h001E, {8'h00, tt});
    $display("test basic done");
    en = 4'hC;
    for (int c = 0; c < 4; c++) begin
      host.send(16'hC963 | (16'(c) << 9), 1'b0);
      settle(2);
      chk("level", 16'(c), {14'h0, lvl});
      chk("selects", {7'h00, 2'b00, 3'b111, 2'(c), 2'b11}, {7'h00, sel});
    end
    $display("test extended done");
    en = 4'h9;
    host.terms(1'b0, 1'b1, 0);
    wait_pc(1'b1, 10);
    settle(55);
    chk("disc fault", 16'h0001, {15'h0, disc});
    host.terms(1'b1, 1'b1, 0);
    settle(10);
    ack();
    chk("ack clear", 16'h0000, {disc, sw[14:0]});
    host.terms(1'b0, 1'b0, 3);
    wait_pc(1'b1, 16);
    settle(55);
    host.terms(1'b1, 1'b1, 2);
    wait_pc(1'b0, 20);
    chk("no fault", 16'h0000, {15'h0, disc});
    host.terms(1'b1, 1'b0, 0);
    wait_pc(1'b1, 16);
    host.terms(1'b1, 1'b1, 0);
    wait_pc(1'b0, 30);
    $display("test terminals done");
    deb = 24'h000006;
    seen = 0;
    host.terms(1'b0, 1'b1, 0);
    settle(3);
    host.terms(1'b1, 1'b1, 0);
    repeat (14) begin
      settle(1);
      seen = seen | int'(pc === 1'b1);
    end
    chk("short pulse", 16'h0000, 16'(seen));
    deb = 24'h000000;
    host.terms(1'b0, 1'b1, 0);
    settle(3);
    host.terms(1'b1, 1'b1, 0);
    wait_pc(1'b1, 8);
    wait_pc(1'b0, 20);
    $display("test debounce done");
    fault = 1'b1;
    settle(4);
    ack();
    chk("event held", 16'h0001, {15'h0, sw[7]});
    fault = 1'b0;
    ack();
    chk("event clear", 16'h0000, {15'h0, sw[7]});
    $display("test event done");
    finish_test();
  end
endmodule
`default_nettype wire
